/* lane_ctrl_pkg.sv */
// package for the low-speed lane control register bank: offsets, field layouts,
// reset values and lane count. assumes a 16-bit management register space.
package lane_ctrl_pkg;

    localparam int LANE_COUNT = 4;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 16;

    // register offsets in the management space
    localparam logic [15:0] LANE_CFG_ONE_ADDR = 16'h0006;
    localparam logic [15:0] LANE_CFG_TWO_ADDR = 16'h0007;

    // reset values of the two registers
    localparam logic [15:0] LANE_CFG_ONE_RESET = 16'hf115;
    localparam logic [15:0] LANE_CFG_TWO_RESET = 16'hdc04;
    localparam logic [15:0] READ_ZERO = 16'h0000;

    // one-hot read selections
    localparam logic [3:0] SEL_LANE0 = 4'h1;
    localparam logic [3:0] SEL_LANE1 = 4'h2;
    localparam logic [3:0] SEL_LANE2 = 4'h4;
    localparam logic [3:0] SEL_LANE3 = 4'h8;

    // lane rate code that is not defined
    localparam logic [1:0] SPEED_RESERVED = 2'h3;

    // lanes left running by the lane-count modes
    localparam logic [3:0] KEEP_ALL = 4'hf;
    localparam logic [3:0] KEEP_TWO = 4'h3;
    localparam logic [3:0] KEEP_ONE = 4'h1;

    // first lane control register
    typedef struct packed {
        logic [3:0] select_mask;   // 15:12
        logic [1:0] rsvd_hi;       // 11:10
        logic [1:0] loop_bw;       // 9:8
        logic [2:0] rsvd_lo;       // 7:5
        logic lane_pll_on;         // 4
        logic [3:0] lane_pll_multiplier; // 3:0
    } cfg_one_t;

    // second lane control register, one copy per lane
    typedef struct packed {
        logic rsvd_hi;             // 15
        logic [2:0] lane_output_swing; // 14:12
        logic lane_signal_loss_detect_on; // 11
        logic tx_lane_on;          // 10
        logic [1:0] tx_lane_speed; // 9:8
        logic [3:0] lane_deemphasis; // 7:4
        logic rsvd_lo;             // 3
        logic rx_lane_on;          // 2
        logic [1:0] rx_lane_speed; // 1:0
    } lane_set_t;

    // decoded multiplier, factor in tenths
    typedef struct packed {
        logic [9:0] factor_x10;
        logic reserved;
    } mult_info_t;

    // factor table entries, in tenths
    localparam logic [9:0] MULT_4 = 10'd40;
    localparam logic [9:0] MULT_5 = 10'd50;
    localparam logic [9:0] MULT_6 = 10'd60;
    localparam logic [9:0] MULT_8 = 10'd80;
    localparam logic [9:0] MULT_10 = 10'd100;
    localparam logic [9:0] MULT_12 = 10'd120;
    localparam logic [9:0] MULT_12P5 = 10'd125;
    localparam logic [9:0] MULT_15 = 10'd150;
    localparam logic [9:0] MULT_20 = 10'd200;
    localparam logic [9:0] MULT_25 = 10'd250;
    localparam logic [9:0] MULT_50 = 10'd500;
    localparam logic [9:0] MULT_65 = 10'd650;
    localparam logic [9:0] MULT_NONE = 10'd0;

endpackage

/* pll_mult_decode.sv */
// decode of the lane pll multiplier code into a factor in tenths.
// assumes a registered code at the input; output is combinational.
`timescale 1ns/1ps
module pll_mult_decode (
    input wire logic [3:0] code,
    output lane_ctrl_pkg::mult_info_t info
);

    // table lookup; reserved codes give zero and a flag
    always_comb begin
        info.reserved = 1'b0;
        unique case (code)
            4'h0: info.factor_x10 = lane_ctrl_pkg::MULT_4; // [R04]
            4'h1: info.factor_x10 = lane_ctrl_pkg::MULT_5; // [R04]
            4'h2: info.factor_x10 = lane_ctrl_pkg::MULT_6; // [R04]
            4'h4: info.factor_x10 = lane_ctrl_pkg::MULT_8; // [R04]
            4'h5: info.factor_x10 = lane_ctrl_pkg::MULT_10; // [R04]
            4'h6: info.factor_x10 = lane_ctrl_pkg::MULT_12; // [R04]
            4'h7: info.factor_x10 = lane_ctrl_pkg::MULT_12P5; // [R04]
            4'h8: info.factor_x10 = lane_ctrl_pkg::MULT_15; // [R04]
            4'h9: info.factor_x10 = lane_ctrl_pkg::MULT_20; // [R04]
            4'ha: info.factor_x10 = lane_ctrl_pkg::MULT_25; // [R04]
            4'hd: info.factor_x10 = lane_ctrl_pkg::MULT_50; // [R04]
            4'he: info.factor_x10 = lane_ctrl_pkg::MULT_65; // [R04]
            default: begin
                info.factor_x10 = lane_ctrl_pkg::MULT_NONE; // [R04]
                info.reserved = 1'b1;
            end
        endcase
    end

endmodule

/* lane_set_store.sv */
// per-lane copies of the second lane control register.
// assumes write strobe and lane mask come from the same clock domain.
`timescale 1ns/1ps
module lane_set_store #(
    parameter int LANES = lane_ctrl_pkg::LANE_COUNT
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [LANES-1:0] lane_mask,
    input wire lane_ctrl_pkg::lane_set_t wr_data,
    output lane_ctrl_pkg::lane_set_t [LANES-1:0] lane_q
);

    // the select mask is four bits wide, so only four lanes can be steered
    if (LANES != lane_ctrl_pkg::LANE_COUNT) begin : g_bad_lanes
        $error("lane_set_store supports exactly four lanes");
    end

    genvar i;
    // one independent copy per lane; unselected lanes keep their value
    for (i = 0; i < LANES; i++) begin : g_lane
        lane_ctrl_pkg::lane_set_t set_d;
        lane_ctrl_pkg::lane_set_t set_q;

        always_comb begin
            set_d = set_q;
            if (wr_en && lane_mask[i]) begin
                set_d = wr_data; // [R15] [R17]
            end
        end

        always_ff @(posedge ref_clk) begin
            if (reset) begin
                set_q <= lane_ctrl_pkg::LANE_CFG_TWO_RESET;
            end else begin
                set_q <= set_d;
            end
        end

        assign lane_q[i] = set_q;
    end

endmodule

/* lane_ctrl_regs.sv */
// control register bank for the low-speed serdes lanes of one channel.
// assumes a management decoder on ref_clk presenting single-cycle register
// read and write strobes; power-down pin is asynchronous, modes are on ref_clk.
//
// Operation
// R01 - pll enable bit, resets to one
// R02 - power-down pin or global bit kills pll
// R03 - four-bit multiplier in bits 3:0, reset 0101
// R04 - decode multiplier code, flag reserved codes
// R05 - swing in bits 14:12, reset 101
// R06 - bit 11 enables loss-of-signal detect
// R07 - bit 10 tx lane enable, power-down forces off
// R08 - tx lane-count modes disable upper lanes
// R09 - tx rate bits 9:8, 11 reserved
// R10 - de-emphasis bits 7:4, reset 0000
// R11 - bit 2 rx lane enable, power-down forces off
// R12 - rx lane-count modes disable upper lanes
// R13 - rx rate bits 1:0, 11 reserved
// R14 - bits 7:5 reserved storage, reset 000
// R15 - second register writes only masked lanes
// R16 - reads return one-hot selected lane only
// R17 - independent per-lane copy of every field
// R18 - forcing gates outputs, not stored bits
`timescale 1ns/1ps
module lane_ctrl_regs #(
    parameter int LANES = lane_ctrl_pkg::LANE_COUNT
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rdata_valid,
    output logic reg_read_invalid,
    input wire logic channel_powerdown_n,
    input wire logic global_powerdown,
    input wire logic two_lane_mode,
    input wire logic one_lane_mode,
    input wire logic kx_mode,
    output logic lane_pll_on,
    output logic [3:0] lane_pll_multiplier,
    output logic [9:0] pll_factor_x10,
    output logic pll_code_reserved,
    output logic [1:0] pll_loop_bw,
    output logic [LANES-1:0] tx_lane_on,
    output logic [LANES-1:0] rx_lane_on,
    output lane_ctrl_pkg::lane_set_t [LANES-1:0] lane_settings,
    output logic [LANES-1:0] speed_code_reserved
);

    if (LANES != lane_ctrl_pkg::LANE_COUNT) begin : g_bad_lanes
        $error("lane_ctrl_regs supports exactly four lanes");
    end

    // power-down pin crosses into ref_clk through two flops
    logic pd_meta_q;
    logic pd_sync_q;
    logic pd_meta_d;
    logic pd_sync_d;

    always_comb begin
        pd_meta_d = channel_powerdown_n;
        pd_sync_d = pd_meta_q;
    end

    // reset as powered down so nothing turns on before the pin is seen
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pd_meta_q <= 1'b0;
            pd_sync_q <= 1'b0;
        end else begin
            pd_meta_q <= pd_meta_d;
            pd_sync_q <= pd_sync_d;
        end
    end

    // only the second sync flop is read; the first may still be settling
    // any of the two power-down sources kills the whole channel
    logic chan_down;
    assign chan_down = !pd_sync_q || global_powerdown; // [R02] [R07] [R11]

    // register decode
    // read and write decoded apart, so one of each may share a cycle
    logic wr_one;
    logic wr_two;
    logic rd_one;
    logic rd_two;
    assign wr_one = reg_wr && (reg_addr == lane_ctrl_pkg::LANE_CFG_ONE_ADDR);
    assign wr_two = reg_wr && (reg_addr == lane_ctrl_pkg::LANE_CFG_TWO_ADDR);
    assign rd_one = reg_rd && (reg_addr == lane_ctrl_pkg::LANE_CFG_ONE_ADDR);
    assign rd_two = reg_rd && (reg_addr == lane_ctrl_pkg::LANE_CFG_TWO_ADDR);

    // first lane control register: all bits are plain read-write storage
    lane_ctrl_pkg::cfg_one_t one_d;
    lane_ctrl_pkg::cfg_one_t one_q;

    // a write replaces the whole word, reserved bits included
    always_comb begin
        one_d = one_q;
        if (wr_one) begin
            one_d = reg_wdata; // [R01] [R03] [R14]
        end
    end

    // reset image: pll on, all lanes selected for writes
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            one_q <= lane_ctrl_pkg::LANE_CFG_ONE_RESET; // [R01] [R03] [R14]
        end else begin
            one_q <= one_d;
        end
    end

    // second register lives per lane, steered by the select mask
    lane_ctrl_pkg::lane_set_t [LANES-1:0] lane_q;

    lane_set_store #(
        .LANES(LANES)
    ) u_store (
        .ref_clk(ref_clk),
        .reset(reset),
        .wr_en(wr_two),
        .lane_mask(one_q.select_mask), // [R15]
        .wr_data(lane_ctrl_pkg::lane_set_t'(reg_wdata)),
        .lane_q(lane_q)
    );

    // multiplier table
    lane_ctrl_pkg::mult_info_t mult_info;

    pll_mult_decode u_mult (
        .code(one_q.lane_pll_multiplier),
        .info(mult_info)
    );

    // lanes allowed by the lane-count mode; one-lane and kx win over two-lane
    logic [3:0] keep_mask;

    always_comb begin
        if (one_lane_mode || kx_mode) begin
            keep_mask = lane_ctrl_pkg::KEEP_ONE; // [R08] [R12]
        end else if (two_lane_mode) begin
            keep_mask = lane_ctrl_pkg::KEEP_TWO; // [R08] [R12]
        end else begin
            keep_mask = lane_ctrl_pkg::KEEP_ALL;
        end
    end

    // effective lane controls; the stored bits stay as software wrote them
    logic [LANES-1:0] tx_on_d;
    logic [LANES-1:0] tx_on_q;
    logic [LANES-1:0] rx_on_d;
    logic [LANES-1:0] rx_on_q;
    logic [LANES-1:0] spd_rsv_d;
    logic [LANES-1:0] spd_rsv_q;

    genvar i;
    for (i = 0; i < LANES; i++) begin : g_lane_on
        // stored bit gated by lane-count mode and power-down
        always_comb begin
            tx_on_d[i] = lane_q[i].tx_lane_on && keep_mask[i] && !chan_down; // [R07] [R08] [R18]
            rx_on_d[i] = lane_q[i].rx_lane_on && keep_mask[i] && !chan_down; // [R11] [R12] [R18]
            spd_rsv_d[i] = (lane_q[i].tx_lane_speed == lane_ctrl_pkg::SPEED_RESERVED) // [R09]
                || (lane_q[i].rx_lane_speed == lane_ctrl_pkg::SPEED_RESERVED); // [R13]
        end
    end

    // analog settings pass straight from storage to the lane drivers
    // one flop stage so the drivers never see a half-written word
    lane_ctrl_pkg::lane_set_t [LANES-1:0] set_out_d;
    lane_ctrl_pkg::lane_set_t [LANES-1:0] set_out_q;

    always_comb begin
        set_out_d = lane_q; // [R05] [R06] [R09] [R10] [R13]
    end

    // pll controls
    logic pll_on_d;
    logic pll_on_q;
    logic [3:0] mult_d;
    logic [3:0] mult_q;
    logic [9:0] factor_d;
    logic [9:0] factor_q;
    logic mult_rsv_d;
    logic mult_rsv_q;
    logic [1:0] bw_d;
    logic [1:0] bw_q;

    // reserved codes are kept as written; only the flag tells
    always_comb begin
        pll_on_d = one_q.lane_pll_on && !chan_down; // [R01] [R02] [R18]
        mult_d = one_q.lane_pll_multiplier; // [R03]
        factor_d = mult_info.factor_x10; // [R04]
        mult_rsv_d = mult_info.reserved; // [R04]
        bw_d = one_q.loop_bw;
    end

    // reset image of the first register, read by field, not by bit position
    localparam lane_ctrl_pkg::cfg_one_t ONE_RESET = lane_ctrl_pkg::LANE_CFG_ONE_RESET;

    // lane output flops; one cycle behind the storage
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tx_on_q <= '0;
            rx_on_q <= '0;
            spd_rsv_q <= '0;
            set_out_q <= {LANES{lane_ctrl_pkg::LANE_CFG_TWO_RESET}};
        end else begin
            tx_on_q <= tx_on_d;
            rx_on_q <= rx_on_d;
            spd_rsv_q <= spd_rsv_d;
            set_out_q <= set_out_d;
        end
    end

    // pll output flops; pll held off in reset until the pin is seen
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pll_on_q <= 1'b0;
            mult_q <= ONE_RESET.lane_pll_multiplier;
            factor_q <= lane_ctrl_pkg::MULT_10;
            mult_rsv_q <= 1'b0;
            bw_q <= ONE_RESET.loop_bw;
        end else begin
            pll_on_q <= pll_on_d;
            mult_q <= mult_d;
            factor_q <= factor_d;
            mult_rsv_q <= mult_rsv_d;
            bw_q <= bw_d;
        end
    end

    // control outputs straight from the flops
    assign tx_lane_on = tx_on_q;
    assign rx_lane_on = rx_on_q;
    assign speed_code_reserved = spd_rsv_q;
    assign lane_settings = set_out_q;
    assign lane_pll_on = pll_on_q;
    assign lane_pll_multiplier = mult_q;
    assign pll_factor_x10 = factor_q;
    assign pll_code_reserved = mult_rsv_q;
    assign pll_loop_bw = bw_q;

    // readback; a mask that is not one-hot reads zero and raises a flag
    logic [15:0] rdata_d;
    logic [15:0] rdata_q;
    logic rvalid_d;
    logic rvalid_q;
    logic rinv_d;
    logic rinv_q;
    logic [15:0] lane_read;
    logic lane_read_ok;

    always_comb begin
        lane_read_ok = 1'b1;
        unique case (one_q.select_mask)
            lane_ctrl_pkg::SEL_LANE0: lane_read = lane_q[0]; // [R16]
            lane_ctrl_pkg::SEL_LANE1: lane_read = lane_q[1]; // [R16]
            lane_ctrl_pkg::SEL_LANE2: lane_read = lane_q[2]; // [R16]
            lane_ctrl_pkg::SEL_LANE3: lane_read = lane_q[3]; // [R16]
            default: begin
                lane_read = lane_ctrl_pkg::READ_ZERO; // [R16]
                lane_read_ok = 1'b0;
            end
        endcase
    end

    // read data is held until the next read; unmapped offsets read zero
    always_comb begin
        rdata_d = rdata_q;
        rinv_d = 1'b0;
        rvalid_d = reg_rd;
        if (rd_one) begin
            rdata_d = one_q;
        end else if (rd_two) begin
            rdata_d = lane_read;
            rinv_d = !lane_read_ok; // [R16]
        end else if (reg_rd) begin
            rdata_d = lane_ctrl_pkg::READ_ZERO;
        end
    end

    // valid and invalid are one-cycle pulses; data holds
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata_q <= lane_ctrl_pkg::READ_ZERO;
            rvalid_q <= 1'b0;
            rinv_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            rinv_q <= rinv_d;
        end
    end

    // read port straight from the flops
    assign reg_rdata = rdata_q;
    assign reg_rdata_valid = rvalid_q;
    assign reg_read_invalid = rinv_q;

endmodule

/* lane_ctrl_regs_props.sv */
// checker for the lane control bank: read answer timing, forcing of enables.
// assumes binding to lane_ctrl_regs, seeing its ports only.
`timescale 1ns/1ps
module lane_ctrl_regs_props #(
    parameter int LANES = 4
) (
    input logic ref_clk,
    input logic reset,
    input logic reg_rd,
    input logic [15:0] reg_rdata,
    input logic reg_rdata_valid,
    input logic reg_read_invalid,
    input logic channel_powerdown_n,
    input logic global_powerdown,
    input logic two_lane_mode,
    input logic one_lane_mode,
    input logic kx_mode,
    input logic lane_pll_on,
    input logic [9:0] pll_factor_x10,
    input logic pll_code_reserved,
    input logic [LANES-1:0] tx_lane_on,
    input logic [LANES-1:0] rx_lane_on,
    input lane_ctrl_pkg::lane_set_t [LANES-1:0] lane_settings
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // read answers stand exactly one cycle after the strobe
    a_read_answer_lat: assert property (reg_rd |=> reg_rdata_valid)
        else $error("read answer late");
    a_answer_has_cause: assert property (reg_rdata_valid |-> $past(reg_rd))
        else $error("read answer without request");
    a_invalid_is_zero: assert property (reg_read_invalid |-> reg_rdata_valid && reg_rdata == 16'h0000)
        else $error("invalid read not zero");
    // forcing terms win over stored enables
    a_global_pll_off: assert property (global_powerdown |=> !lane_pll_on)
        else $error("pll on in global power-down");
    a_global_lanes_off: assert property (global_powerdown |=> tx_lane_on == '0 && rx_lane_on == '0)
        else $error("lane on in global power-down");
    // pin passes a two-flop synchroniser, so three low samples are needed
    a_pin_forces_off: assert property (!channel_powerdown_n [*3] |=> !lane_pll_on && tx_lane_on == '0)
        else $error("pin power-down ignored");
    a_one_lane_tx: assert property ((one_lane_mode || kx_mode) |=> tx_lane_on[LANES-1:1] == '0)
        else $error("upper tx lanes on in one-lane mode");
    a_two_lane_rx: assert property (two_lane_mode |=> rx_lane_on[LANES-1:2] == '0)
        else $error("upper rx lanes on in two-lane mode");
    a_tx_needs_bit: assert property (tx_lane_on[0] |-> lane_settings[0].tx_lane_on)
        else $error("tx lane on with bit clear");
    a_rx_needs_bit: assert property (rx_lane_on[1] |-> lane_settings[1].rx_lane_on)
        else $error("rx lane on with bit clear");
    a_reserved_factor: assert property (pll_code_reserved |-> pll_factor_x10 == 10'h000)
        else $error("reserved code with factor");

    c_invalid_read: cover property (reg_read_invalid);
    c_global_pulse: cover property (global_powerdown ##1 !global_powerdown);
    c_reserved_code: cover property (pll_code_reserved);
endmodule

bind lane_ctrl_regs lane_ctrl_regs_props #(.LANES(LANES)) i_lane_ctrl_regs_props (
    .ref_clk(ref_clk), .reset(reset), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid), .reg_read_invalid(reg_read_invalid),
    .channel_powerdown_n(channel_powerdown_n), .global_powerdown(global_powerdown),
    .two_lane_mode(two_lane_mode), .one_lane_mode(one_lane_mode), .kx_mode(kx_mode),
    .lane_pll_on(lane_pll_on), .pll_factor_x10(pll_factor_x10), .pll_code_reserved(pll_code_reserved),
    .tx_lane_on(tx_lane_on), .rx_lane_on(rx_lane_on), .lane_settings(lane_settings)
);

/* mgmt_host.sv */
// behavioural management host issuing single-cycle register strobes.
// assumes the bank answers a read exactly one cycle after taking it.
`timescale 1ns/1ps
module mgmt_host (
    input logic ref_clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata,
    input logic [15:0] reg_rdata,
    input logic reg_rdata_valid,
    input logic reg_read_invalid
);
    // idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
    end

    // address and data scrambled after release so stale values never pass
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge ref_clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    // answer sampled in the one cycle it stands; caller judges the flag
    task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic [1:0] st);
        @(posedge ref_clk);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge ref_clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
        st = {reg_rdata_valid, reg_read_invalid};
    endtask
endmodule

/* lane_ctrl_regs_tb_top.sv */
// self-checking bench for lane_ctrl_regs against an array model of the lanes.
// assumes mgmt_host as the register master and a 100 MHz clock.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fail_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module lane_ctrl_regs_tb_top;
    logic ref_clk, reset, reg_wr, reg_rd, reg_rdata_valid, reg_read_invalid;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, cfg1, d;
    logic channel_powerdown_n, global_powerdown, two_lane_mode, one_lane_mode, kx_mode;
    logic lane_pll_on, pll_code_reserved;
    logic [3:0] lane_pll_multiplier, tx_lane_on, rx_lane_on, speed_code_reserved, m;
    logic [9:0] pll_factor_x10;
    logic [1:0] pll_loop_bw;
    lane_ctrl_pkg::lane_set_t [3:0] lane_settings;
    logic [15:0] lane_m [4];
    int fx [16] = '{40, 50, 60, 0, 80, 100, 120, 125, 150, 200, 250, 0, 0, 500, 650, 0};
    int fail_count = 0;
    int compares = 0;

    lane_ctrl_regs #(.LANES(4)) i_lane_ctrl_regs (.ref_clk(ref_clk), .reset(reset), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rdata_valid(reg_rdata_valid), .reg_read_invalid(reg_read_invalid),
        .channel_powerdown_n(channel_powerdown_n), .global_powerdown(global_powerdown),
        .two_lane_mode(two_lane_mode), .one_lane_mode(one_lane_mode), .kx_mode(kx_mode),
        .lane_pll_on(lane_pll_on), .lane_pll_multiplier(lane_pll_multiplier), .pll_factor_x10(pll_factor_x10),
        .pll_code_reserved(pll_code_reserved), .pll_loop_bw(pll_loop_bw), .tx_lane_on(tx_lane_on),
        .rx_lane_on(rx_lane_on), .lane_settings(lane_settings), .speed_code_reserved(speed_code_reserved));
    mgmt_host i_mgmt_host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
        .reg_read_invalid(reg_read_invalid));

    // 100 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // expected effective enables: stored bit gated by pin, global bit and lane-count mode
    function automatic logic [3:0] exp_en(input int b);
        logic [3:0] k;
        logic [3:0] e;
        k = (one_lane_mode || kx_mode) ? 4'h1 : (two_lane_mode ? 4'h3 : 4'hf);
        for (int i = 0; i < 4; i++) e[i] = lane_m[i][b] & k[i] & channel_powerdown_n & ~global_powerdown;
        return e;
    endfunction

    task automatic rdc(input logic [15:0] a, input logic [15:0] ex, input logic inv);
        logic [1:0] st;
        i_mgmt_host.rd(a, d, st);
        `CHK("rdata", ex, d)
        `CHK("rd_status", {1'b1, inv}, st)
    endtask

    task automatic setcfg1(input logic [15:0] v);
        cfg1 = v;
        i_mgmt_host.wr(16'h0006, v);
    endtask

    // outputs settle two edges after the last write
    task automatic chk_all();
        repeat (2) @(posedge ref_clk);
        #1;
        `CHK("pll_on", cfg1[4] & channel_powerdown_n & ~global_powerdown, lane_pll_on)
        `CHK("tx_on", exp_en(10), tx_lane_on)
        `CHK("rx_on", exp_en(2), rx_lane_on)
        for (int i = 0; i < 4; i++) begin
            `CHK("lane_set", lane_m[i], lane_settings[i])
            `CHK("spd_rsv", lane_m[i][9:8] == 2'h3 || lane_m[i][1:0] == 2'h3, speed_code_reserved[i])
            setcfg1({4'h1 << i, cfg1[11:0]});
            rdc(16'h0007, lane_m[i], 1'b0);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // watchdog at 20k cycles, far beyond the expected run of about a thousand
    initial begin
        #200000;
        fail_count++;
        $display("[FAIL] watchdog expired");
        results();
    end

    // main sequence
    initial begin
        {reset, channel_powerdown_n, global_powerdown, two_lane_mode, one_lane_mode, kx_mode} = 6'h30;
        cfg1 = 16'hf115;
        for (int i = 0; i < 4; i++) lane_m[i] = 16'hdc04;
        void'($urandom(32'hc0e7));
        repeat (10) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        rdc(16'h0006, 16'hf115, 1'b0);
        rdc(16'h0007, 16'h0000, 1'b1);
        i_mgmt_host.wr(16'h0009, 16'hffff);
        rdc(16'h0009, 16'h0000, 1'b0);
        rdc(16'h0006, 16'hf115, 1'b0);
        `CHK("mult", 4'h5, lane_pll_multiplier)
        `CHK("factor", 10'd100, pll_factor_x10)
        `CHK("loop_bw", 2'h1, pll_loop_bw)
        chk_all();
        $display("test reset_values done");
        for (int n = 0; n < 8; n++) begin
            m = (n == 0) ? 4'h0 : 4'($urandom);
            setcfg1({m, cfg1[11:0]});
            d = 16'($urandom);
            i_mgmt_host.wr(16'h0007, d);
            for (int i = 0; i < 4; i++) if (m[i]) lane_m[i] = d;
            chk_all();
        end
        $display("test masked_writes done");
        for (int c = 0; c < 16; c++) begin
            setcfg1({4'h1, 4'($urandom), 3'($urandom), 1'($urandom), 4'(c)});
            repeat (2) @(posedge ref_clk);
            #1;
            `CHK("mult", 4'(c), lane_pll_multiplier)
            `CHK("factor", fx[c][9:0], pll_factor_x10)
            `CHK("code_rsv", fx[c] == 0, pll_code_reserved)
            `CHK("pll_on", cfg1[4], lane_pll_on)
            `CHK("loop_bw", cfg1[9:8], pll_loop_bw)
            rdc(16'h0006, cfg1, 1'b0);
        end
        $display("test multiplier done");
        for (int k = 0; k < 32; k++) begin
            {channel_powerdown_n, global_powerdown, two_lane_mode, one_lane_mode, kx_mode} = 5'(k) ^ 5'h10;
            repeat (2) @(posedge ref_clk);
            chk_all();
        end
        $display("test power_and_modes done");
        results();
    end
endmodule
